// ---- common/rcto_defines.svh ----
`ifndef RCTO_DEFINES_SVH
`define RCTO_DEFINES_SVH

// register indices; byte address is four times the index
`define RCTO_IDX_STATUS   12'h003
`define RCTO_IDX_POWER_CONTROL     12'h08e
`define RCTO_IDX_INTEN    12'h040
`define RCTO_IDX_INTFLAG  12'h041

// core status bit positions
`define RCTO_ST_TO        4
`define RCTO_ST_PD        3
`define RCTO_ST_UPPER_HI  7
`define RCTO_ST_UPPER_LO  5
`define RCTO_ST_WMASK     8'he7

// power control bit positions
`define RCTO_PC_ULP       5
`define RCTO_PC_SBO       4
`define RCTO_PC_POR       1
`define RCTO_PC_BOR       0
`define RCTO_PC_WMASK     8'h33

// values taken at asynchronous (power-on) reset
`define RCTO_STATUS_RST   8'h18
`define RCTO_POWER_CONTROL_RST     8'h10
`define RCTO_BYTE_ZERO    8'h00

// start-up timing, in ticks of the timing oscillators
`define RCTO_POWERUP_DELAY_TIMER_MS      64
`define RCTO_LFO_KHZ      31
`define RCTO_POWERUP_DELAY_TIMER_TICKS   (`RCTO_POWERUP_DELAY_TIMER_MS * `RCTO_LFO_KHZ)
`define RCTO_OST_TICKS    1024
`define RCTO_CNT_W        11

// bus answers
`define RCTO_RESP_OKAY    2'h0
`define RCTO_RESP_DECERR  2'h3

`endif

// ---- common/rcto_pkg.sv ----
package rcto_pkg;

  // oscillator configuration
  typedef enum logic [2:0] {
    OSC_CRYSTAL_LOW    = 3'h0,
    OSC_CRYSTAL_MEDIUM = 3'h1,
    OSC_CRYSTAL_HIGH   = 3'h2,
    OSC_RESISTOR_CAP   = 3'h3,
    OSC_EXTERNAL_CLOCK = 3'h4,
    OSC_INTERNAL       = 3'h5
  } rcto_osc_t;

  // brown-out mode selection
  typedef enum logic [1:0] {
    BOR_OFF      = 2'h0,
    BOR_SOFTWARE = 2'h1,
    BOR_NO_SLEEP = 2'h2,
    BOR_ON       = 2'h3
  } rcto_bor_t;

  // start-up sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_START = 4'h1,
    ST_POWERUP_DELAY_TIMER  = 4'h2,
    ST_OST   = 4'h4,
    ST_RUN   = 4'h8
  } rcto_state_t;

  // configuration word fields
  typedef struct packed {
    rcto_osc_t oscMode;
    logic      powerupDelayDisableN;
    rcto_bor_t brownoutModeSel;
  } rcto_cfg_t;

  // reset and wake causes from the core
  typedef struct packed {
    logic powerOn;
    logic brownout;
    logic watchdogTimer;
    logic intWake;
    logic sleepEnter;
  } rcto_evt_t;

endpackage

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

// one compare: counted, and a mismatch is reported at once
`define TB_CHK(nm, ex, gt) \
  begin total_checks++; if ((gt) !== (ex)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, ex, gt); end end

module testbench
  import rcto_pkg::*;
;
  logic        core_clk, rst_n, master_clear_n, lfoscClk, oscClk;
  rcto_cfg_t   cfg;
  rcto_evt_t   evt;
  logic [7:0]  pcCurrent, intFlagSet, pcLowByte, intEnable;
  logic        coreHold, brownoutDetectEn, asleep;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          n_fail, total_checks, cyc;
  logic [7:0]  st, pcn, ie, ifl, r8;  // reference images of the registers

  rcto_top rcto_top_inst (
    .core_clk, .rst_n, .cfg, .evt, .master_clear_n, .lfoscClk, .oscClk,
    .pcCurrent, .intFlagSet, .coreHold, .brownoutDetectEn, .pcLowByte,
    .intEnable, .asleep, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // slow pins toggle every cycle so the long start-up counts end quickly
  always @(posedge core_clk) begin
    lfoscClk <= ~lfoscClk;
    oscClk <= ~oscClk;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      final_report;
    end
  end

  task automatic final_report;
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // write one register; each channel is held until its own handshake
  task automatic axw(input logic [13:0] a, input logic [7:0] d,
                     input logic [3:0] s, input logic [1:0] ex);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    `TB_CHK("bresp", ex, s_axi_bresp)
  endtask

  task automatic axr(input logic [13:0] a, input logic [1:0] ex,
                     output logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[7:0];
    `TB_CHK("rresp", ex, s_axi_rresp)
    `TB_CHK("rdataHigh", 24'h000000, s_axi_rdata[31:8])
  endtask

  // m hides bits that the hardware leaves unknown
  task automatic chk_regs(input logic [7:0] m);
    axr(14'h00c, 2'h0, r8);
    `TB_CHK("status", st, r8)
    axr(14'h238, 2'h0, r8);
    `TB_CHK("powerControl", pcn & m, r8 & m)
    axr(14'h100, 2'h0, r8);
    `TB_CHK("intEnReg", ie, r8)
    axr(14'h104, 2'h0, r8);
    `TB_CHK("intFlagReg", ifl, r8)
    `TB_CHK("intEnable", ie, intEnable)
  endtask

  // counts cycles until the core is let go; bounded so a hang still ends
  task automatic hold_len(input int lo, input int hi);
    int n;
    n = 0;
    while (coreHold !== 1'b0 && n < 7000) begin
      @(posedge core_clk);
      n++;
    end
    `TB_CHK("holdLen", 1'b1, n >= lo && n <= hi)
  endtask

  task automatic ev(input rcto_evt_t e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
    #1;
  endtask

  task automatic setf(input logic [7:0] f);
    @(posedge core_clk);
    intFlagSet <= f;
    @(posedge core_clk);
    intFlagSet <= 8'h00;
    ifl = ifl | f;
  endtask

  // pin is held well past its synchroniser before release
  task automatic ext_reset;
    @(posedge core_clk);
    master_clear_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    master_clear_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // events: 10 power-on, 08 brown-out, 04 watchdog, 02 int wake, 01 sleep
  initial begin
    rcto_cfg_t  cfgs[6];
    int         lo[6], hi[6];
    logic [7:0] d;
    cfgs = '{'{OSC_CRYSTAL_HIGH, 1'b0, BOR_ON},
             '{OSC_CRYSTAL_LOW, 1'b1, BOR_ON},
             '{OSC_CRYSTAL_MEDIUM, 1'b1, BOR_ON},
             '{OSC_EXTERNAL_CLOCK, 1'b1, BOR_ON},
             '{OSC_RESISTOR_CAP, 1'b0, BOR_ON},
             '{OSC_INTERNAL, 1'b0, BOR_ON}};
    lo = '{6000, 2040, 2040, 0, 3950, 3950};
    hi = '{6080, 2090, 2090, 10, 4010, 4010};
    void'($urandom(32'h480e));
    {master_clear_n, lfoscClk, oscClk, evt} <= 8'h80;
    {pcCurrent, intFlagSet, s_axi_awaddr, s_axi_araddr} <= 44'h0;
    {s_axi_wdata, s_axi_wstrb} <= 36'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    {s_axi_arvalid, s_axi_rready} <= 2'h0;
    for (int i = 0; i < 6; i++) begin
      cfg <= cfgs[i];
      rst_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      hold_len(lo[i], hi[i]);
    end
    {st, pcn, ie, ifl} = 32'h18100000;
    chk_regs(8'hff);
    axr(14'h0ffc, 2'h3, r8);
    `TB_CHK("unmappedRead", 8'h00, r8)
    axw(14'h0ffc, 8'h5a, 4'h1, 2'h3);
    d = 8'($urandom) | 8'h03;
    axw(14'h238, d, 4'h1, 2'h0);
    pcn = d & 8'h33;
    d = 8'($urandom);
    axw(14'h00c, d, 4'h1, 2'h0);
    st = (d & 8'he7) | (st & 8'h18);
    d = 8'($urandom);
    axw(14'h100, d, 4'h1, 2'h0);
    ie = d;
    axw(14'h100, ~d, 4'h0, 2'h0);
    setf(8'($urandom));
    chk_regs(8'hff);
    // watchdog reset while awake: timeout flag drops; upper status bits, ULP bit, enables and flags clear
    pcCurrent <= 8'($urandom);
    ev(5'h04);
    `TB_CHK("pcLowByte", 8'h00, pcLowByte)
    {st, pcn, ie, ifl} = {st & 8'h0f, pcn & 8'h13, 16'h0000};
    chk_regs(8'hff);
    axw(14'h238, 8'h33, 4'h1, 2'h0);
    axw(14'h100, 8'($urandom), 4'h1, 2'h0);
    ext_reset;
    {st, pcn, ie, ifl} = {st & 8'h1f, 8'h13, 16'h0000};
    chk_regs(8'hff);
    // sleep, then watchdog wake: enables and flags survive
    d = 8'($urandom);
    axw(14'h100, d, 4'h1, 2'h0);
    ie = d;
    setf(8'($urandom));
    ev(5'h01);
    st = (st & 8'he7) | 8'h10;
    `TB_CHK("asleep", 1'b1, asleep)
    ev(5'h04);
    st = st & 8'he7;
    `TB_CHK("asleep", 1'b0, asleep)
    chk_regs(8'hff);
    ev(5'h01);
    ext_reset;
    {st, ie, ifl} = {(st & 8'h07) | 8'h10, 16'h0000};
    chk_regs(8'hff);
    d = 8'($urandom);
    pcCurrent <= d;
    ev(5'h01);
    ev(5'h02);
    `TB_CHK("pcLowByte", d + 8'h01, pcLowByte)
    chk_regs(8'hff);
    // brown-out keeps the power-on flag and restarts the delay
    axw(14'h238, 8'h33, 4'h1, 2'h0);
    ev(5'h08);
    {st, pcn, ie, ifl} = {(st & 8'h07) | 8'h18, 8'h12, 16'h0000};
    hold_len(3900, 4010);
    chk_regs(8'hff);
    cfg <= '{OSC_INTERNAL, 1'b0, BOR_SOFTWARE};
    axw(14'h238, 8'h03, 4'h1, 2'h0);
    pcn = 8'h03;
    `TB_CHK("detectEn", 1'b0, brownoutDetectEn)
    ev(5'h08);
    chk_regs(8'hff);
    axw(14'h238, 8'h13, 4'h1, 2'h0);
    pcn = 8'h13;
    `TB_CHK("detectEn", 1'b1, brownoutDetectEn)
    cfg <= '{OSC_INTERNAL, 1'b0, BOR_OFF};
    @(posedge core_clk);
    #1;
    `TB_CHK("detectEn", 1'b0, brownoutDetectEn)
    // mode 10: detection drops while asleep and returns on wake
    cfg <= '{OSC_INTERNAL, 1'b0, BOR_NO_SLEEP};
    ev(5'h01);
    `TB_CHK("detectEnSleep", 1'b0, brownoutDetectEn)
    ev(5'h02);
    `TB_CHK("detectEnWake", 1'b1, brownoutDetectEn)
    cfg <= '{OSC_INTERNAL, 1'b0, BOR_ON};
    ev(5'h10);
    {st, pcn, ie, ifl} = {(st & 8'h07) | 8'h18, 8'h10, 16'h0000};
    `TB_CHK("pcLowByte", 8'h00, pcLowByte)
    hold_len(3900, 4010);
    chk_regs(8'hfe);
    final_report;
  end
endmodule // testbench

`default_nettype wire

// ---- verilog/rcto_top.sv ----
// Contract
// - a power control register at 8Eh holds two last-reset cause flags.
// - the brown-out flag in bit 0 is unknown after power-on; sw sets it.
// - a brown-out reset clears the active-low brown-out flag to 0.
// - with brown-out mode 00 the brown-out flag is a don't-care.
// - the power-on flag in bit 1 clears on power-on only.
// - start-up delay depends on oscillator mode and power-up timer enable.
// - power-on and brown-out resets set flags as tabulated.
// - pin reset keeps flags, watchdog reset clears timeout, wake both.
// - pin reset in sleep sets timeout and clears power-down.
// - power control bits 5,4,1,0 reset to 01qq or 0uuu.
// - status resets to 0001 1xxx or 000q quuu.
// - pc low byte clears on resets and takes pc plus one on wake.
// - the power-up timer holds reset 64 ms from the 31 kHz oscillator.
// - in brown-out mode 01 the software enable switches detection.
`timescale 1ns/1ps
`default_nettype none
`include "rcto_defines.svh"

module rcto_top
  import rcto_pkg::*;
(
  input  wire logic        core_clk,        // core clock, 10 MHz
  input  wire logic        rst_n,           // async reset, power-on
  input  wire rcto_cfg_t   cfg,             // configuration word
  input  wire rcto_evt_t   evt,             // one-cycle cause pulses
  input  wire logic        master_clear_n,  // external reset pin
  input  wire logic        lfoscClk,        // 31 kHz oscillator
  input  wire logic        oscClk,          // main oscillator pin
  input  wire logic [7:0]  pcCurrent,       // current pc low byte
  input  wire logic [7:0]  intFlagSet,      // interrupt flag pulses
  output logic             coreHold,        // core kept in reset
  output logic             brownoutDetectEn,// brown-out detect on
  output logic [7:0]       pcLowByte,       // pc low byte
  output logic [7:0]       intEnable,       // interrupt enables
  output logic             asleep,          // core sleeping
  input  wire logic [13:0] s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write strobes
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [13:0] s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready     // read data ready
);

  // word index of a byte address
  function automatic logic [11:0] wordIdx(input logic [13:0] a);
    return a[13:2];
  endfunction

  // true for an implemented register index
  function automatic logic isMapped(input logic [11:0] i);
    return (i == `RCTO_IDX_STATUS) || (i == `RCTO_IDX_POWER_CONTROL) ||
           (i == `RCTO_IDX_INTEN) || (i == `RCTO_IDX_INTFLAG);
  endfunction

  // pin synchronisers: master_clear_n, slow oscillator, main oscillator
  logic [2:0] pinRaw;
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic [2:0] syncPrev_reg;
  assign pinRaw = {oscClk, lfoscClk, master_clear_n};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gSync
      // master_clear_n idles high so no false edge appears after reset
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          syncA_reg[g]    <= (g == 0);
          syncB_reg[g]    <= (g == 0);
          syncPrev_reg[g] <= (g == 0);
        end else begin
          syncA_reg[g]    <= pinRaw[g];
          syncB_reg[g]    <= syncA_reg[g];
          syncPrev_reg[g] <= syncB_reg[g];
        end
      end
    end
  endgenerate

  logic mclrFall;
  logic lfoTick;
  logic oscTick;
  assign mclrFall = syncPrev_reg[0] & ~syncB_reg[0];
  assign lfoTick  = syncB_reg[1] & ~syncPrev_reg[1];
  assign oscTick  = syncB_reg[2] & ~syncPrev_reg[2];

  // registers
  logic [7:0]  status_reg,  status_next;
  logic [7:0]  power_control_reg,    power_control_next;
  logic [7:0]  intEn_reg,   intEn_next;
  logic [7:0]  intFlag_reg, intFlag_next;
  logic [7:0]  pcl_reg,     pcl_next;
  logic        asleep_reg,  asleep_next;
  rcto_state_t state_reg,   state_next;
  logic [`RCTO_CNT_W-1:0] cnt_reg, cnt_next;

  // brown-out detect enable by mode
  assign brownoutDetectEn =
      (cfg.brownoutModeSel == BOR_ON) |
      ((cfg.brownoutModeSel == BOR_SOFTWARE) &
       power_control_reg[`RCTO_PC_SBO]) |
      ((cfg.brownoutModeSel == BOR_NO_SLEEP) & ~asleep_reg);

  // cause decode; power-on outranks brown-out outranks the rest
  logic porHit, borHit, wdtReset, wdtWake, mclrRun, mclrSleep;
  logic intWakeHit, anyReset, wake, sleepHit;
  assign porHit     = evt.powerOn;
  assign borHit     = evt.brownout & brownoutDetectEn & ~porHit;
  assign wdtReset   = evt.watchdogTimer & ~asleep_reg;
  assign wdtWake    = evt.watchdogTimer & asleep_reg;
  assign mclrRun    = mclrFall & ~asleep_reg;
  assign mclrSleep  = mclrFall & asleep_reg;
  assign intWakeHit = evt.intWake & asleep_reg;
  assign anyReset   = porHit | borHit | wdtReset | mclrFall;
  assign wake       = (wdtWake | intWakeHit) & ~anyReset;
  assign sleepHit   = evt.sleepEnter & ~asleep_reg & ~anyReset;

  // crystal modes need the oscillator start-up count
  logic isCrystal;
  logic pwrtEnabled;
  assign isCrystal   = (cfg.oscMode == OSC_CRYSTAL_LOW) |
                       (cfg.oscMode == OSC_CRYSTAL_MEDIUM) |
                       (cfg.oscMode == OSC_CRYSTAL_HIGH);
  assign pwrtEnabled = ~cfg.powerupDelayDisableN;

  // bus write channel capture
  logic        awHeld_reg, wHeld_reg, bValid_reg;
  logic [13:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic [1:0]  bResp_reg;
  logic        wrFire;
  logic        wrLane0;
  logic [11:0] wrIdx;
  assign wrFire  = awHeld_reg & wHeld_reg & ~bValid_reg;
  assign wrIdx   = wordIdx(awAddr_reg);
  assign wrLane0 = wrFire & wStrb_reg[0];

  logic wrStatus, wrPcon, wrIntEn, wrIntFlag;
  assign wrStatus  = wrLane0 & (wrIdx == `RCTO_IDX_STATUS);
  assign wrPcon    = wrLane0 & (wrIdx == `RCTO_IDX_POWER_CONTROL);
  assign wrIntEn   = wrLane0 & (wrIdx == `RCTO_IDX_INTEN);
  assign wrIntFlag = wrLane0 & (wrIdx == `RCTO_IDX_INTFLAG);

  logic [7:0] wByte;
  logic [7:0] statusSw;
  logic [7:0] pconSw;
  assign wByte    = wData_reg[7:0];
  assign statusSw = wrStatus ?
      ((status_reg & ~`RCTO_ST_WMASK) | (wByte & `RCTO_ST_WMASK)) :
      status_reg;
  assign pconSw   = wrPcon ?
      ((power_control_reg & ~`RCTO_PC_WMASK) | (wByte & `RCTO_PC_WMASK)) :
      power_control_reg;

  // flag update: hardware causes override a same-cycle software write
  always_comb begin
    status_next = statusSw;
    power_control_next   = pconSw;
    asleep_next = asleep_reg;
    if (anyReset) begin
      status_next[`RCTO_ST_UPPER_HI:`RCTO_ST_UPPER_LO] = 3'h0;
      power_control_next[`RCTO_PC_ULP] = 1'b0;
      asleep_next = 1'b0;
    end
    if (porHit) begin
      power_control_next[`RCTO_PC_POR]  = 1'b0;
      power_control_next[`RCTO_PC_SBO]  = 1'b1;
      status_next[`RCTO_ST_TO] = 1'b1;
      status_next[`RCTO_ST_PD] = 1'b1;
    end else if (borHit) begin
      power_control_next[`RCTO_PC_BOR]  = 1'b0;
      power_control_next[`RCTO_PC_SBO]  = 1'b1;
      status_next[`RCTO_ST_TO] = 1'b1;
      status_next[`RCTO_ST_PD] = 1'b1;
    end else if (wdtReset) begin
      status_next[`RCTO_ST_TO] = 1'b0;
    end else if (mclrSleep) begin
      status_next[`RCTO_ST_TO] = 1'b1;
      status_next[`RCTO_ST_PD] = 1'b0;
    end else if (wdtWake) begin
      status_next[`RCTO_ST_TO] = 1'b0;
      status_next[`RCTO_ST_PD] = 1'b0;
      asleep_next = 1'b0;
    end else if (intWakeHit) begin
      status_next[`RCTO_ST_TO] = 1'b1;
      status_next[`RCTO_ST_PD] = 1'b0;
      asleep_next = 1'b0;
    end else if (sleepHit) begin
      status_next[`RCTO_ST_TO] = 1'b1;
      status_next[`RCTO_ST_PD] = 1'b0;
      asleep_next = 1'b1;
    end
  end

  // pc low byte and interrupt registers
  assign pcl_next = anyReset ? `RCTO_BYTE_ZERO :
                    wake ? 8'(pcCurrent + 8'h01) : pcCurrent;
  assign intEn_next = anyReset ? `RCTO_BYTE_ZERO :
                      wrIntEn ? wByte : intEn_reg;
  // write 1 clears a flag; a new set in the same cycle wins
  assign intFlag_next = anyReset ? `RCTO_BYTE_ZERO :
      ((intFlag_reg & ~(wrIntFlag ? wByte : 8'h00)) | intFlagSet);

  // start-up sequencer
  logic pwrtDone;
  logic ostDone;
  assign pwrtDone = lfoTick &
      (cnt_reg == `RCTO_CNT_W'(`RCTO_POWERUP_DELAY_TIMER_TICKS - 1));
  assign ostDone  = oscTick &
      (cnt_reg == `RCTO_CNT_W'(`RCTO_OST_TICKS - 1));

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_START: begin
        cnt_next = '0;
        if (pwrtEnabled) begin
          state_next = ST_POWERUP_DELAY_TIMER;
        end else if (isCrystal) begin
          state_next = ST_OST;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_POWERUP_DELAY_TIMER: begin
        if (pwrtDone) begin
          cnt_next   = '0;
          state_next = isCrystal ? ST_OST : ST_RUN;
        end else if (lfoTick) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_OST: begin
        if (ostDone) begin
          cnt_next   = '0;
          state_next = ST_RUN;
        end else if (oscTick) begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_RUN: begin
        if (wake && isCrystal) begin
          cnt_next   = '0;
          state_next = ST_OST;
        end
      end
      default: begin
        state_next = ST_START;
      end
    endcase
    // power-up timer restarts on power-on or brown-out
    if (porHit | borHit) begin
      state_next = ST_START;
    end
  end

  assign coreHold = (state_reg != ST_RUN) | anyReset;

  // register flip-flops; reset is treated as a power-on
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg  <= `RCTO_STATUS_RST;
      power_control_reg    <= `RCTO_POWER_CONTROL_RST;
      intEn_reg   <= `RCTO_BYTE_ZERO;
      intFlag_reg <= `RCTO_BYTE_ZERO;
      pcl_reg     <= `RCTO_BYTE_ZERO;
      asleep_reg  <= 1'b0;
      state_reg   <= ST_START;
      cnt_reg     <= '0;
    end else begin
      status_reg  <= status_next;
      power_control_reg    <= power_control_next;
      intEn_reg   <= intEn_next;
      intFlag_reg <= intFlag_next;
      pcl_reg     <= pcl_next;
      asleep_reg  <= asleep_next;
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
    end
  end

  assign pcLowByte = pcl_reg;
  assign intEnable = intEn_reg;
  assign asleep    = asleep_reg;

  // bus write path: address and data taken in either order
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      bValid_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= '0;
      wStrb_reg  <= '0;
      bResp_reg  <= `RCTO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bValid_reg <= 1'b1;
        bResp_reg  <= isMapped(wrIdx) ? `RCTO_RESP_OKAY :
                                        `RCTO_RESP_DECERR;
      end else if (s_axi_bready) begin
        bValid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~awHeld_reg;
  assign s_axi_wready  = ~wHeld_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;

  // bus read path: one cycle to data; unmapped reads return zero
  logic [11:0] rdIdx;
  logic [7:0]  rdByte;
  logic        rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0]  rResp_reg;
  assign rdIdx  = wordIdx(s_axi_araddr);
  assign rdByte = (rdIdx == `RCTO_IDX_STATUS)  ? status_reg :
                  (rdIdx == `RCTO_IDX_POWER_CONTROL)    ? power_control_reg :
                  (rdIdx == `RCTO_IDX_INTEN)   ? intEn_reg :
                  (rdIdx == `RCTO_IDX_INTFLAG) ? intFlag_reg :
                                                 `RCTO_BYTE_ZERO;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rValid_reg <= 1'b0;
      rData_reg  <= '0;
      rResp_reg  <= `RCTO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_reg <= 1'b1;
      rData_reg  <= {24'h000000, rdByte};
      rResp_reg  <= isMapped(rdIdx) ? `RCTO_RESP_OKAY :
                                      `RCTO_RESP_DECERR;
    end else if (s_axi_rready) begin
      rValid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = ~rValid_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;

  // checks
  sequence s_powerup_delay_timer_done;
    (state_reg == ST_POWERUP_DELAY_TIMER) && pwrtDone && !porHit && !borHit;
  endsequence
  sequence s_leave_powerup_delay_timer;
    (state_reg == ST_OST) || (state_reg == ST_RUN);
  endsequence

  property p_powerup_delay_timer_exit;
    @(posedge core_clk) disable iff (!rst_n)
      s_powerup_delay_timer_done |=> s_leave_powerup_delay_timer;
  endproperty
  a_powerup_delay_timer_exit: assert property (p_powerup_delay_timer_exit)
    else $error("power-up timer did not finish on its last tick");

  property p_por_flags;
    @(posedge core_clk) disable iff (!rst_n)
      porHit |=> !power_control_reg[`RCTO_PC_POR] && status_reg[`RCTO_ST_TO]
                 && status_reg[`RCTO_ST_PD] && coreHold;
  endproperty
  a_por_flags: assert property (p_por_flags)
    else $error("power-on flags wrong");

  property p_bor_flag;
    @(posedge core_clk) disable iff (!rst_n)
      borHit |=> !power_control_reg[`RCTO_PC_BOR] && power_control_reg[`RCTO_PC_SBO]
                 && $stable(power_control_reg[`RCTO_PC_POR]);
  endproperty
  a_bor_flag: assert property (p_bor_flag)
    else $error("brown-out flags wrong");

  property p_bor_gate;
    @(posedge core_clk) disable iff (!rst_n)
      (cfg.brownoutModeSel == BOR_OFF) |-> !brownoutDetectEn && !borHit;
  endproperty
  a_bor_gate: assert property (p_bor_gate)
    else $error("brown-out active with mode off");

  property p_master_clear_n_keep;
    @(posedge core_clk) disable iff (!rst_n)
      (mclrRun && !porHit && !borHit && !evt.watchdogTimer && !wrLane0)
        |=> $stable(status_reg[`RCTO_ST_TO:`RCTO_ST_PD])
            && $stable(power_control_reg[`RCTO_PC_POR:`RCTO_PC_BOR]);
  endproperty
  a_master_clear_n_keep: assert property (p_master_clear_n_keep)
    else $error("master_clear_n changed cause flags");

  property p_wdt_wake;
    @(posedge core_clk) disable iff (!rst_n)
      (wdtWake && !anyReset) |=> !status_reg[`RCTO_ST_TO]
                                 && !status_reg[`RCTO_ST_PD] && !asleep;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("watchdog wake flags wrong");

  property p_master_clear_n_sleep;
    @(posedge core_clk) disable iff (!rst_n)
      (mclrSleep && !porHit && !borHit && !evt.watchdogTimer)
        |=> status_reg[`RCTO_ST_TO] && !status_reg[`RCTO_ST_PD];
  endproperty
  a_master_clear_n_sleep: assert property (p_master_clear_n_sleep)
    else $error("master_clear_n in sleep flags wrong");

  property p_pcl;
    @(posedge core_clk) disable iff (!rst_n)
      anyReset |=> (pcLowByte == 8'h00) && (intEnable == 8'h00)
                   && !power_control_reg[`RCTO_PC_ULP];
  endproperty
  a_pcl: assert property (p_pcl)
    else $error("reset did not clear pc low byte or enables");

  property p_sw_bor;
    @(posedge core_clk) disable iff (!rst_n)
      (cfg.brownoutModeSel == BOR_SOFTWARE)
        |-> (brownoutDetectEn == power_control_reg[`RCTO_PC_SBO]);
  endproperty
  a_sw_bor: assert property (p_sw_bor)
    else $error("software brown-out enable ignored");

endmodule // rcto_top

`default_nettype wire
